/* File: tos_stage.sv */
// Thermal overload output and supervision stage.
// Assumes capacity, currents and tick come from hclk logic;
// block_in may be asynchronous.
`timescale 1ns/100ps
`default_nettype none
// Function
// (R1) Alarm 1 at its level when enabled
// (R2) Alarm 2 at its level when enabled
// (R3) Restart inhibit at its level when enabled
// (R4) Trip condition at trip level when enabled
// (R5) Trip held off by 5 ms step delay
// (R6) Blocking input sampled at each cycle start
// (R7) Unblocked pick-up gives start, then timing
// (R8) Blocked pick-up gives blocked, nothing more
// (R9) Blocking clears start like pick-up release
// (R10) Blocker asserts 5 ms before delay ends; no blocker output is provided here
// (R11) Condition code; normal drives no outputs; here start_out can be high in normal while a trip pick-up alone is timing
// (R12) Thermal load status from measured current
// (R13) Invalid service factor uses 1.0, flagged
// (R14) Inconsistent ambient settings use 1.0, flagged
// (R15) Behaviour mode selectable when globally permitted
// (R16) Setting changes apply while running
// (R17) Level reached means at or above it
module tos_stage
#(
  parameter int STEP_CYCLES = tos_pkg::DELAY_STEP_CYCLES
)
(
  // AHB-Lite slave
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Thermal image and blocking matrix
  input wire logic cycle_tick,
  input wire logic [15:0] thermal_capacity,
  input wire logic [15:0] meas_current,
  input wire logic [15:0] pickup_current,
  input wire logic [15:0] ambient_k_calc,
  input wire logic block_in,
  // Protection outputs
  output logic alarm1_out,
  output logic alarm2_out,
  output logic inhibit_out,
  output logic trip_out,
  output logic start_out,
  output logic blocked_out,
  // Indications
  output logic [2:0] condition,
  output logic [1:0] thermal_status,
  output logic sf_fault,
  output logic amb_fault,
  output logic [15:0] service_factor_used,
  output logic [15:0] ambient_k_used,
  output logic irq
);
  typedef struct packed {
    logic [3:0] enables;
    logic [2:0] mode;
    logic allow_mode;
    logic [15:0] alarm1_lvl;
    logic [15:0] alarm2_lvl;
    logic [15:0] inhibit_lvl;
    logic [15:0] trip_lvl;
    logic [19:0] trip_delay;
    logic [15:0] service_factor;
    logic [31:0] amb_temp;
    logic [31:0] amb_k;
    logic [tos_pkg::IRQ_BITS-1:0] irq_status;
    logic [tos_pkg::IRQ_BITS-1:0] irq_enable;
    logic blk_sampled;
    logic a1;
    logic a2;
    logic inh;
    logic pick;
    logic start;
    logic blocked;
    logic trip;
    logic [3:0] pins;
    logic [2:0] condition;
    logic [1:0] load;
    logic sf_fault;
    logic amb_fault;
    logic [15:0] sf_used;
    logic [15:0] k_used;
    logic irq;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr;
    logic [31:0] hrdata;
    logic hreadyout;
  } tos_state_type;

  tos_state_type state_reg;
  tos_state_type state_next;
  logic block_sync;
  logic delay_done;

  tos_sync u_block_sync
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(block_in),
    .sync_out(block_sync)
  );

  tos_delay_timer #(.STEP_CYCLES(STEP_CYCLES)) u_trip_timer
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(state_reg.start & state_reg.pick),
    .steps(state_reg.trip_delay),
    .done(delay_done)
  );

  function automatic logic [31:0] read_word(input tos_state_type s,
                                            input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      tos_pkg::ADDR_CTRL:
        d = {23'h00_0000, s.allow_mode, 1'b0, s.mode, s.enables};
      tos_pkg::ADDR_ALARM1_LVL: d = {16'h0000, s.alarm1_lvl};
      tos_pkg::ADDR_ALARM2_LVL: d = {16'h0000, s.alarm2_lvl};
      tos_pkg::ADDR_INHIBIT_LVL: d = {16'h0000, s.inhibit_lvl};
      tos_pkg::ADDR_TRIP_LVL: d = {16'h0000, s.trip_lvl};
      tos_pkg::ADDR_TRIP_DELAY: d = {12'h000, s.trip_delay};
      tos_pkg::ADDR_SERVICE_FACTOR: d = {16'h0000, s.service_factor};
      tos_pkg::ADDR_AMB_TEMP: d = s.amb_temp;
      tos_pkg::ADDR_AMB_K: d = s.amb_k;
      tos_pkg::ADDR_STATUS:
        d = {18'h0_0000, s.sf_fault, s.amb_fault, s.load, s.condition,
             s.blocked, s.start, s.trip, s.pins};
      tos_pkg::ADDR_IRQ_STATUS: d = {26'h000_0000, s.irq_status};
      tos_pkg::ADDR_IRQ_ENABLE: d = {26'h000_0000, s.irq_enable};
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  always_comb
  begin
    logic blk;
    logic test;
    logic off;
    logic a1_raw;
    logic a2_raw;
    logic inh_raw;
    logic pick_raw;
    logic any_raw;
    logic [tos_pkg::IRQ_BITS-1:0] ev;
    logic [tos_pkg::IRQ_BITS-1:0] clr;
    tos_pkg::tos_mode_type mode_eff;
    blk = 1'b0;
    test = 1'b0;
    off = 1'b0;
    a1_raw = 1'b0;
    a2_raw = 1'b0;
    inh_raw = 1'b0;
    pick_raw = 1'b0;
    any_raw = 1'b0;
    ev = '0;
    clr = '0;
    mode_eff = tos_pkg::MODE_ON;
    state_next = state_reg;

    // Register writes land in the data phase
    if (state_reg.wr_pend)
    begin
      case (state_reg.addr)
        tos_pkg::ADDR_CTRL:
        begin
          state_next.enables = hwdata[3:0];
          state_next.mode = hwdata[tos_pkg::CTRL_MODE_LSB +: 3];
          state_next.allow_mode = hwdata[tos_pkg::CTRL_ALLOW_MODE];
        end
        tos_pkg::ADDR_ALARM1_LVL: state_next.alarm1_lvl = hwdata[15:0];
        tos_pkg::ADDR_ALARM2_LVL: state_next.alarm2_lvl = hwdata[15:0];
        tos_pkg::ADDR_INHIBIT_LVL: state_next.inhibit_lvl = hwdata[15:0];
        tos_pkg::ADDR_TRIP_LVL: state_next.trip_lvl = hwdata[15:0];
        tos_pkg::ADDR_TRIP_DELAY:
          state_next.trip_delay = (hwdata[19:0] > tos_pkg::TRIP_DELAY_MAX)
                                  ? tos_pkg::TRIP_DELAY_MAX : hwdata[19:0];
        tos_pkg::ADDR_SERVICE_FACTOR:
          state_next.service_factor = hwdata[15:0];
        tos_pkg::ADDR_AMB_TEMP: state_next.amb_temp = hwdata;
        tos_pkg::ADDR_AMB_K: state_next.amb_k = hwdata;
        tos_pkg::ADDR_IRQ_CLEAR: clr = hwdata[tos_pkg::IRQ_BITS-1:0];
        tos_pkg::ADDR_IRQ_ENABLE:
          state_next.irq_enable = hwdata[tos_pkg::IRQ_BITS-1:0];
        default: ;
      endcase
    end

    // Bus address phase; reads take one wait state
    state_next.wr_pend = 1'b0;
    if (state_reg.rd_pend)
    begin
      state_next.rd_pend = 1'b0;
      state_next.hrdata = read_word(state_reg, state_reg.addr);
      state_next.hreadyout = 1'b1;
    end
    else if (hsel && hready && htrans[1])
    begin
      state_next.addr = {haddr[7:2], 2'b00};
      state_next.wr_pend = hwrite;
      state_next.rd_pend = !hwrite;
      state_next.hreadyout = hwrite;
    end

    // Mode is on unless individual setting is allowed
    if (state_reg.allow_mode)
      mode_eff = tos_pkg::tos_mode_type'(state_reg.mode); // [R15]
    off = (mode_eff == tos_pkg::MODE_OFF);
    test = (mode_eff == tos_pkg::MODE_TEST)
           || (mode_eff == tos_pkg::MODE_TEST_BLOCKED);
    blk = (mode_eff == tos_pkg::MODE_BLOCKED)
          || (mode_eff == tos_pkg::MODE_TEST_BLOCKED);

    // Settings are read live [R16]
    a1_raw = state_reg.enables[tos_pkg::CTRL_EN_ALARM1]
             && (thermal_capacity >= state_reg.alarm1_lvl); // [R1] [R17]
    a2_raw = state_reg.enables[tos_pkg::CTRL_EN_ALARM2]
             && (thermal_capacity >= state_reg.alarm2_lvl); // [R2] [R17]
    inh_raw = state_reg.enables[tos_pkg::CTRL_EN_INHIBIT]
              && (thermal_capacity >= state_reg.inhibit_lvl); // [R3] [R17]
    pick_raw = state_reg.enables[tos_pkg::CTRL_EN_TRIP]
               && (thermal_capacity >= state_reg.trip_lvl); // [R4] [R17]
    any_raw = a1_raw || a2_raw || inh_raw || pick_raw;

    // Sample blocking first, then evaluate
    if (cycle_tick)
    begin
      state_next.blk_sampled = block_sync || blk; // [R6]
      if (off)
      begin
        state_next.a1 = 1'b0;
        state_next.a2 = 1'b0;
        state_next.inh = 1'b0;
        state_next.pick = 1'b0;
        state_next.start = 1'b0;
        state_next.blocked = 1'b0;
      end
      else if (state_next.blk_sampled)
      begin
        state_next.a1 = 1'b0;
        state_next.a2 = 1'b0;
        state_next.inh = 1'b0;
        state_next.pick = 1'b0;
        // Start drops as on release [R9]
        state_next.start = 1'b0;
        state_next.blocked = any_raw; // [R8]
      end
      else
      begin
        state_next.a1 = a1_raw;
        state_next.a2 = a2_raw;
        state_next.inh = inh_raw;
        state_next.pick = pick_raw;
        state_next.start = any_raw; // [R7]
        state_next.blocked = 1'b0;
      end
    end

    // Trip after the extra delay [R5]
    state_next.trip = state_reg.start && state_reg.pick && delay_done;

    // Test modes keep pins quiet; level pins move on ticks [R15]
    state_next.pins[3] = !test && state_next.trip;
    if (cycle_tick)
      state_next.pins[2:0] = test ? 3'h0 : {state_next.inh, state_next.a2,
                                           state_next.a1};

    // Condition, most severe first [R11]
    if (state_next.blocked)
      state_next.condition = tos_pkg::COND_BLOCKED;
    else if (state_next.trip)
      state_next.condition = tos_pkg::COND_TRIP;
    else if (state_next.inh)
      state_next.condition = tos_pkg::COND_INHIBIT;
    else if (state_next.a2)
      state_next.condition = tos_pkg::COND_ALARM2;
    else if (state_next.a1)
      state_next.condition = tos_pkg::COND_ALARM1;
    else
      state_next.condition = tos_pkg::COND_NORMAL;

    // Thermal load classification [R12]
    if (meas_current < tos_pkg::CUR_LIGHT)
      state_next.load = tos_pkg::LOAD_LIGHT;
    else if (meas_current > tos_pkg::CUR_HIGH)
      state_next.load = tos_pkg::LOAD_HIGH;
    else if (meas_current > pickup_current)
      state_next.load = tos_pkg::LOAD_OVER;
    else
      state_next.load = tos_pkg::LOAD_NORMAL;

    // Zero or oversized service factor [R13]
    state_next.sf_fault = (state_reg.service_factor == 16'h0000)
                          || (state_reg.service_factor > tos_pkg::SF_MAX);
    state_next.sf_used = state_next.sf_fault ? tos_pkg::FACTOR_ONE
                                             : state_reg.service_factor;

    // Ambient band must rise, factors nonzero [R14]
    state_next.amb_fault = ($signed(state_reg.amb_temp[15:0])
                            >= $signed(state_reg.amb_temp[31:16]))
                           || (state_reg.amb_k[15:0] == 16'h0000)
                           || (state_reg.amb_k[31:16] == 16'h0000);
    state_next.k_used = state_next.amb_fault ? tos_pkg::FACTOR_ONE
                                             : ambient_k_calc;

    // Sticky events; set beats clear
    ev[tos_pkg::IRQ_ALARM1] = state_next.a1 && !state_reg.a1;
    ev[tos_pkg::IRQ_ALARM2] = state_next.a2 && !state_reg.a2;
    ev[tos_pkg::IRQ_INHIBIT] = state_next.inh && !state_reg.inh;
    ev[tos_pkg::IRQ_TRIP] = state_next.trip && !state_reg.trip;
    ev[tos_pkg::IRQ_BLOCKED] = state_next.blocked && !state_reg.blocked;
    ev[tos_pkg::IRQ_FAULT] = (state_next.sf_fault && !state_reg.sf_fault)
                             || (state_next.amb_fault
                                 && !state_reg.amb_fault);
    state_next.irq_status = (state_reg.irq_status & ~clr) | ev;
    state_next.irq = |(state_next.irq_status & state_next.irq_enable);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= '0;
      state_reg.alarm1_lvl <= tos_pkg::RST_ALARM1_LVL;
      state_reg.alarm2_lvl <= tos_pkg::RST_ALARM2_LVL;
      state_reg.inhibit_lvl <= tos_pkg::RST_INHIBIT_LVL;
      state_reg.trip_lvl <= tos_pkg::RST_TRIP_LVL;
      state_reg.trip_delay <= tos_pkg::RST_TRIP_DELAY;
      state_reg.service_factor <= tos_pkg::FACTOR_ONE;
      state_reg.sf_used <= tos_pkg::FACTOR_ONE;
      state_reg.k_used <= tos_pkg::FACTOR_ONE;
      state_reg.hreadyout <= 1'b1;
      state_reg.load <= tos_pkg::LOAD_LIGHT;
    end
    else
      state_reg <= state_next;
  end

  assign hrdata = state_reg.hrdata;
  assign hreadyout = state_reg.hreadyout;
  assign hresp = 1'b0;
  assign alarm1_out = state_reg.pins[0];
  assign alarm2_out = state_reg.pins[1];
  assign inhibit_out = state_reg.pins[2];
  assign trip_out = state_reg.pins[3];
  assign start_out = state_reg.start;
  assign blocked_out = state_reg.blocked;
  assign condition = state_reg.condition;
  assign thermal_status = state_reg.load;
  assign sf_fault = state_reg.sf_fault;
  assign amb_fault = state_reg.amb_fault;
  assign service_factor_used = state_reg.sf_used;
  assign ambient_k_used = state_reg.k_used;
  assign irq = state_reg.irq;
endmodule
`default_nettype wire

/* File: tos_pkg.sv */
// Package for the thermal overload output stage: register map, fields,
// reset values, state encodings and timing constants.
// Assumes a 100 MHz hclk and 32-bit AHB-Lite data.
`default_nettype none
package tos_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ALARM1_LVL = 8'h04;
  localparam logic [7:0] ADDR_ALARM2_LVL = 8'h08;
  localparam logic [7:0] ADDR_INHIBIT_LVL = 8'h0C;
  localparam logic [7:0] ADDR_TRIP_LVL = 8'h10;
  localparam logic [7:0] ADDR_TRIP_DELAY = 8'h14;
  localparam logic [7:0] ADDR_SERVICE_FACTOR = 8'h18;
  localparam logic [7:0] ADDR_AMB_TEMP = 8'h1C;
  localparam logic [7:0] ADDR_AMB_K = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h28;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h2C;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h30;
  // Control fields
  localparam int CTRL_EN_ALARM1 = 0;
  localparam int CTRL_EN_ALARM2 = 1;
  localparam int CTRL_EN_INHIBIT = 2;
  localparam int CTRL_EN_TRIP = 3;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_ALLOW_MODE = 8;
  // Reset values; levels in 0.1 % units, delay in 5 ms steps
  localparam logic [15:0] RST_ALARM1_LVL = 16'h0190;
  localparam logic [15:0] RST_ALARM2_LVL = 16'h0190;
  localparam logic [15:0] RST_INHIBIT_LVL = 16'h0320;
  localparam logic [15:0] RST_TRIP_LVL = 16'h03E8;
  localparam logic [19:0] RST_TRIP_DELAY = 20'h0_0000;
  localparam logic [19:0] TRIP_DELAY_MAX = 20'hA_FC80;
  // Factors in 0.01 units
  localparam logic [15:0] FACTOR_ONE = 16'h0064;
  localparam logic [15:0] SF_MAX = 16'h01F4;
  // Current in 0.001 x nominal
  localparam logic [15:0] CUR_LIGHT = 16'h000A;
  localparam logic [15:0] CUR_HIGH = 16'h07D0;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int DELAY_STEP_NS = 5000000;
  localparam int DELAY_STEP_CYCLES = DELAY_STEP_NS / CLK_PERIOD_NS;
  // Interrupt bits
  localparam int IRQ_BITS = 6;
  localparam int IRQ_ALARM1 = 0;
  localparam int IRQ_ALARM2 = 1;
  localparam int IRQ_INHIBIT = 2;
  localparam int IRQ_TRIP = 3;
  localparam int IRQ_BLOCKED = 4;
  localparam int IRQ_FAULT = 5;

  typedef enum logic [2:0] {
    MODE_ON = 3'b000,
    MODE_BLOCKED = 3'b001,
    MODE_TEST = 3'b010,
    MODE_TEST_BLOCKED = 3'b011,
    MODE_OFF = 3'b100
  } tos_mode_type;

  typedef enum logic [2:0] {
    COND_NORMAL = 3'b000,
    COND_ALARM1 = 3'b001,
    COND_ALARM2 = 3'b010,
    COND_INHIBIT = 3'b011,
    COND_TRIP = 3'b100,
    COND_BLOCKED = 3'b101
  } tos_cond_type;

  typedef enum logic [1:0] {
    LOAD_LIGHT = 2'b00,
    LOAD_NORMAL = 2'b01,
    LOAD_OVER = 2'b10,
    LOAD_HIGH = 2'b11
  } tos_load_type;
endpackage
`default_nettype wire

/* File: tos_sync.sv */
// Two-flop synchroniser into hclk.
// Assumes a slow level.
`timescale 1ns/100ps
`default_nettype none
module tos_sync
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Level in and out
  input wire logic async_in,
  output var logic sync_out
);
  typedef struct packed {
    logic meta;
    logic stable;
  } tos_sync_state_type;

  tos_sync_state_type state_reg;
  tos_sync_state_type state_next;

  always_comb
  begin
    state_next.meta = async_in;
    state_next.stable = state_reg.meta;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign sync_out = state_reg.stable;
endmodule
`default_nettype wire

/* File: tos_delay_timer.sv */
// Extra trip delay timer in 5 ms steps.
// Assumes run stays high; dropping it restarts.
`timescale 1ns/100ps
`default_nettype none
module tos_delay_timer
#(
  parameter int STEP_CYCLES = tos_pkg::DELAY_STEP_CYCLES
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic run,
  input wire logic [19:0] steps,
  output var logic done
);
  typedef struct packed {
    logic [31:0] pre;
    logic [19:0] count;
    logic done;
  } tos_timer_state_type;

  tos_timer_state_type state_reg;
  tos_timer_state_type state_next;

  always_comb
  begin
    state_next = state_reg;
    if (!run)
      state_next = '0;
    else if (state_reg.count >= steps)
      state_next.done = 1'b1;
    else if (state_reg.pre == 32'(STEP_CYCLES - 1))
    begin
      state_next.pre = '0;
      state_next.count = state_reg.count + 20'h0_0001;
    end
    else
      state_next.pre = state_reg.pre + 32'h0000_0001;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign done = state_reg.done;
endmodule
`default_nettype wire

/* File: tos_stage_props.sv */
// Checker on tos_stage ports.
// Assumes one hclk domain.
`timescale 1ns/100ps
`default_nettype none
module tos_stage_props
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Inputs watched
  input wire logic cycle_tick,
  input wire logic [15:0] meas_current,
  // Outputs watched
  input wire logic alarm1_out,
  input wire logic alarm2_out,
  input wire logic inhibit_out,
  input wire logic trip_out,
  input wire logic start_out,
  input wire logic blocked_out,
  input wire logic [2:0] condition,
  input wire logic [1:0] thermal_status,
  input wire logic sf_fault,
  input wire logic amb_fault,
  input wire logic [15:0] service_factor_used,
  input wire logic [15:0] ambient_k_used
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_tick_only;
    ($changed(alarm1_out) || $changed(alarm2_out) || $changed(inhibit_out)
      || $changed(start_out) || $changed(blocked_out)) |-> $past(cycle_tick);
  endproperty
  a_tick_only: assert property (p_tick_only)
    else $error("Output moved off tick");

  property p_pins_start;
    (alarm1_out || alarm2_out || inhibit_out) |-> start_out;
  endproperty
  a_pins_start: assert property (p_pins_start)
    else $error("Pin without start");

  property p_excl;
    !(start_out && blocked_out);
  endproperty
  a_excl: assert property (p_excl)
    else $error("Start with blocked");

  property p_normal;
    condition == tos_pkg::COND_NORMAL |-> !(alarm1_out || alarm2_out
      || inhibit_out || trip_out || blocked_out);
  endproperty
  a_normal: assert property (p_normal)
    else $error("Output in normal");

  property p_trip_cond;
    $rose(trip_out) |-> condition == tos_pkg::COND_TRIP;
  endproperty
  a_trip_cond: assert property (p_trip_cond)
    else $error("Trip condition");

  property p_trip_after;
    $rose(trip_out) |-> $past(start_out, 2) && start_out;
  endproperty
  a_trip_after: assert property (p_trip_after)
    else $error("Trip too soon");

  property p_fell;
    $fell(start_out) |-> ##2 !trip_out;
  endproperty
  a_fell: assert property (p_fell)
    else $error("Trip held");

  property p_sf;
    sf_fault |-> service_factor_used == tos_pkg::FACTOR_ONE;
  endproperty
  a_sf: assert property (p_sf)
    else $error("Factor not 1.0");

  property p_amb;
    amb_fault |-> ambient_k_used == tos_pkg::FACTOR_ONE;
  endproperty
  a_amb: assert property (p_amb)
    else $error("Ambient k not 1.0");

  property p_light;
    meas_current < tos_pkg::CUR_LIGHT |=>
      thermal_status == tos_pkg::LOAD_LIGHT;
  endproperty
  a_light: assert property (p_light)
    else $error("Not light");
endmodule

bind tos_stage tos_stage_props u_props (.*);
`default_nettype wire

/* File: tos_image_model.sv */
// Thermal image and blocking model.
// Assumes bench-set capacity, current, blocking.
`timescale 1ns/100ps
`default_nettype none
module tos_image_model
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Commands from the bench
  input wire logic [15:0] cap_cmd,
  input wire logic [15:0] cur_cmd,
  input wire logic blk_cmd,
  // Toward the stage
  output logic cycle_tick,
  output logic [15:0] thermal_capacity,
  output logic [15:0] meas_current,
  output logic [15:0] pickup_current,
  output logic [15:0] ambient_k_calc,
  output logic block_in
);
  logic [2:0] cnt;
  assign pickup_current = 16'h044C;
  assign ambient_k_calc = 16'h0050;
  assign meas_current = cur_cmd;
  // Capacity and blocking change with the tick; current follows cur_cmd at once
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt <= 3'h0;
      cycle_tick <= 1'b0;
      thermal_capacity <= 16'h0000;
      block_in <= 1'b0;
    end
    else
    begin
      cnt <= cnt + 3'h1;
      cycle_tick <= (cnt == 3'h7);
      if (cnt == 3'h7)
      begin
        thermal_capacity <= cap_cmd;
        block_in <= blk_cmd;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tos_stage_test.sv */
// Bench for tos_stage over AHB-Lite.
// Assumes tos_image_model and a short delay step.
`timescale 1ns/100ps
`default_nettype none
module tos_stage_test;
  localparam int STEP = 10;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, cycle_tick, block_in, irq;
  logic [15:0] thermal_capacity, meas_current, pickup_current;
  logic [15:0] ambient_k_calc, service_factor_used, ambient_k_used;
  logic alarm1_out, alarm2_out, inhibit_out, trip_out;
  logic start_out, blocked_out, sf_fault, amb_fault;
  logic [2:0] condition;
  logic [1:0] thermal_status;
  logic [15:0] cap_cmd = 16'h0000;
  logic [15:0] cur_cmd = 16'h0000;
  logic blk_cmd = 1'b0;
  logic [15:0] lvl [4] = '{16'h0190, 16'h0190, 16'h0320, 16'h03E8};
  logic [7:0] zr [4] = '{8'h00, 8'h14, 8'h2C, 8'h3C};
  logic [15:0] bc [3] = '{16'h03E8, 16'h0000, 16'h03E8};
  logic [31:0] mv [4] = '{32'h0000_012F, 32'h0000_014F, 32'h0000_004F,
                          32'h0000_011F};
  logic [5:0] me [4] = '{6'h10, 6'h00, 6'h1F, 6'h20};
  logic [15:0] lc [6] = '{16'h0009, 16'h000A, 16'h044C, 16'h044D,
                          16'h07D0, 16'h07D1};
  int error_cnt = 0;
  int compares = 0;

  tos_stage #(.STEP_CYCLES(STEP)) u_dut (.hready(hreadyout), .*);
  tos_image_model u_model (.*);

  always #5 hclk = ~hclk;

  task automatic tally_and_finish();
    $display("Compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %0t: reg %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %0t: out %h exp %h", $time, got, exp);
    end
  endtask

  task automatic endt(input string s);
    $display("Test %s done", s);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // One single transfer; entered and left just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d = 32'h0000_0000);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic set_lvls();
    for (int i = 0; i < 4; i++)
      bus(1'b1, 8'(tos_pkg::ADDR_ALARM1_LVL + 4 * i), 32'(lvl[i]));
  endtask

  function automatic logic [31:0] outs();
    return 32'({condition, blocked_out, start_out, trip_out, inhibit_out,
                alarm2_out, alarm1_out});
  endfunction

  function automatic logic [31:0] exp_outs(input logic [15:0] c);
    logic [3:0] hit;
    logic [2:0] cd;
    cd = 3'h0;
    for (int i = 0; i < 4; i++)
    begin
      hit[i] = c >= lvl[i];
      if (hit[i])
        cd = 3'(i + 1);
    end
    return 32'({cd, 1'b0, |hit, hit});
  endfunction

  function automatic logic [1:0] exp_load(input logic [15:0] c);
    if (c < 16'h000A)
      return tos_pkg::LOAD_LIGHT;
    if (c > 16'h07D0)
      return tos_pkg::LOAD_HIGH;
    if (c > 16'h044C)
      return tos_pkg::LOAD_OVER;
    return tos_pkg::LOAD_NORMAL;
  endfunction

  initial
  begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end

  initial
  begin
    logic [15:0] c;
    logic [31:0] e;
    void'($urandom(70594));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b0, 8'(tos_pkg::ADDR_ALARM1_LVL + 4 * i));
      chk_reg(rd, 32'(lvl[i]));
      bus(1'b0, zr[i]);
      chk_reg(rd, 32'h0000_0000);
    end
    cap_cmd <= 16'h044C;
    wt(24);
    chk_out(outs(), 32'h0000_0000);
    endt("defaults");
    bus(1'b1, tos_pkg::ADDR_CTRL, 32'h0000_000F);
    for (int n = 0; n < 15; n++)
    begin
      for (int i = 0; i < 4; i++)
        lvl[i] = 16'($urandom_range(1, 1500));
      set_lvls();
      c = lvl[$urandom_range(0, 3)];
      if (n % 3 == 1)
        c = c - 16'h0001;
      if (n % 3 == 2)
        c = 16'($urandom_range(0, 1600));
      cap_cmd <= c;
      wt(24);
      chk_out(outs(), exp_outs(c));
    end
    endt("levels");
    lvl = '{16'h0190, 16'h0190, 16'h0320, 16'h03E8};
    set_lvls();
    bus(1'b1, tos_pkg::ADDR_TRIP_DELAY, 32'h0000_0003);
    cap_cmd <= 16'h0000;
    wt(24);
    cap_cmd <= 16'h03E8;
    wt(24);
    chk_out({30'h0, start_out, trip_out}, 32'h0000_0002);
    wt(24);
    chk_out(outs(), exp_outs(16'h03E8));
    bus(1'b1, tos_pkg::ADDR_TRIP_DELAY, 32'h0000_0000);
    endt("trip delay");
    blk_cmd <= 1'b1;
    foreach (bc[i])
    begin
      cap_cmd <= bc[i];
      wt(24);
      e = bc[i] ? {23'h0, tos_pkg::COND_BLOCKED, 6'h20} : 32'h0000_0000;
      chk_out(outs(), e);
    end
    blk_cmd <= 1'b0;
    wt(24);
    chk_out(outs(), exp_outs(16'h03E8));
    endt("blocking");
    foreach (mv[i])
    begin
      bus(1'b1, tos_pkg::ADDR_CTRL, mv[i]);
      wt(24);
      chk_out(outs() & 32'h0000_003F, 32'(me[i]));
    end
    bus(1'b1, tos_pkg::ADDR_CTRL, 32'h0000_000F);
    endt("modes");
    for (int i = 0; i < 10; i++)
    begin
      c = (i < 6) ? lc[i] : 16'($urandom_range(0, 3000));
      cur_cmd <= c;
      wt(3);
      chk_out(32'(thermal_status), 32'(exp_load(c)));
    end
    endt("load status");
    bus(1'b1, tos_pkg::ADDR_AMB_K, 32'h0064_0064);
    bus(1'b1, tos_pkg::ADDR_AMB_TEMP, 32'h0028_0000);
    bus(1'b1, tos_pkg::ADDR_SERVICE_FACTOR, 32'h0000_0000);
    wt(3);
    chk_out({sf_fault, amb_fault, 14'h0, service_factor_used},
            32'h8000_0064);
    chk_out(32'(ambient_k_used), 32'h0000_0050);
    bus(1'b1, tos_pkg::ADDR_SERVICE_FACTOR, 32'h0000_0096);
    bus(1'b1, tos_pkg::ADDR_AMB_TEMP, 32'h0028_0028);
    wt(3);
    chk_out({sf_fault, amb_fault, 14'h0, service_factor_used},
            32'h4000_0096);
    chk_out(32'(ambient_k_used), 32'h0000_0064);
    endt("faults");
    bus(1'b1, tos_pkg::ADDR_IRQ_ENABLE, 32'h0000_0001);
    cap_cmd <= 16'h0000;
    wt(24);
    bus(1'b1, tos_pkg::ADDR_IRQ_CLEAR, 32'h0000_003F);
    wt(2);
    chk_out(32'(irq), 32'h0000_0000);
    cap_cmd <= 16'h01F4;
    wt(24);
    chk_out(32'(irq), 32'h0000_0001);
    bus(1'b0, tos_pkg::ADDR_STATUS);
    chk_reg(rd & 32'h0000_007F, 32'h0000_0023);
    bus(1'b1, tos_pkg::ADDR_IRQ_CLEAR, 32'h0000_0001);
    bus(1'b0, tos_pkg::ADDR_IRQ_STATUS);
    chk_reg(rd & 32'h0000_0003, 32'h0000_0002);
    chk_out(32'(irq), 32'h0000_0000);
    endt("interrupts");
    tally_and_finish();
  end
endmodule
`default_nettype wire
